// ==== hw/fsec_pkg.sv ====
// Constants, command codes and status layout for the flash status and error checker.
// Assumes one 250 MHz system clock and a byte-wide command bus from the CPU or a programmer.

`default_nettype none

package fsec_pkg;

  // -------------------------------------------------------------------------
  // Command codes
  // -------------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;

  // -------------------------------------------------------------------------
  // Status byte layout and reset values
  // -------------------------------------------------------------------------
  localparam int         STAT_PROG_ERR_POS  = 4;
  localparam int         STAT_ERASE_ERR_POS = 5;
  localparam int         STAT_READY_POS     = 7;
  localparam logic       PROG_ERR_RST       = 1'b0;
  localparam logic       ERASE_ERR_RST      = 1'b0;
  localparam logic       READY_RST          = 1'b1;

  // -------------------------------------------------------------------------
  // Flash array map; the ranges are plain defaults for the allocated blocks
  // -------------------------------------------------------------------------
  localparam int         ADDR_W    = 16;
  localparam logic [15:0] BLK0_LO  = 16'hE000;
  localparam logic [15:0] BLK0_HI  = 16'hEFFF;
  localparam logic [15:0] BLK1_LO  = 16'hF000;
  localparam logic [15:0] BLK1_HI  = 16'hFFFF;

  // -------------------------------------------------------------------------
  // Serial programming mode codes
  // -------------------------------------------------------------------------
  localparam logic [1:0] SER_MODE_2 = 2'h2;
  localparam logic [1:0] SER_MODE_3 = 2'h3;

  // Command sequencing phases.
  typedef enum logic [2:0] {
    FSEC_PH_IDLE,
    FSEC_PH_PROG2,
    FSEC_PH_ERASE2,
    FSEC_PH_BUSY_PROG,
    FSEC_PH_BUSY_ERASE
  } fsec_phase_type;

endpackage : fsec_pkg

`default_nettype wire

// ==== hw/fsec_sticky_flag.sv ====
// One sticky error flag: set by hardware events, cleared by a command.
// Assumes set and clear are synchronous one-cycle requests from the sequencer.

`timescale 1ns/100ps
`default_nettype none

module fsec_sticky_flag
  import fsec_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic set,
  input  wire logic clr,
  output var  logic flag
);

  // -------------------------------------------------------------------------
  // Flag storage
  // -------------------------------------------------------------------------
  logic flag_r;

  // Set wins over clear so an error landing on the clear cycle is never lost.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_r <= RST_VAL;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

  assign flag = flag_r;

endmodule : fsec_sticky_flag

`default_nettype wire

// ==== hw/fsec_status_check.sv ====
// Status and error checking for the flash rewrite sequencer.
// Assumes byte-wide command cycles as one-cycle strobes and a flash core that
// reports the end of each auto operation with a one-cycle done and a fail level.

`timescale 1ns/100ps
`default_nettype none

module fsec_status_check
  import fsec_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              cmd_wr,
  input  wire logic              cmd_rd,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]        cmd_wdata,
  output var  logic [7:0]        status_read_data,
  input  wire logic [7:0]        array_rdata,
  input  wire logic              global_rewrite_enable,
  input  wire logic              block0_rewrite_lock,
  input  wire logic              block1_rewrite_lock,
  output var  logic              core_prog_start,
  output var  logic              core_erase_start,
  output var  logic [ADDR_W-1:0] core_addr,
  output var  logic [7:0]        core_wdata,
  input  wire logic              core_done,
  input  wire logic              core_fail,
  input  wire logic [1:0]        serial_mode_sel,
  output var  logic              serial_mode_ok,
  output var  logic              sequencer_ready_mirror,
  output var  logic              erase_error_mirror,
  output var  logic              program_error_mirror,
  output var  logic              status_mode
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  fsec_phase_type    phase_r;
  fsec_phase_type    phase_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic              status_mode_r;
  logic              status_mode_nxt;
  logic              prog_start_r;
  logic              erase_start_r;
  logic              prog_start_nxt;
  logic              erase_start_nxt;
  logic [7:0]        wdata_r;
  logic [7:0]        rd_data_r;
  logic              seq_err;
  logic              prog_fail;
  logic              erase_fail;
  logic              clr_cmd;
  logic              prog_err;
  logic              erase_err;
  logic              err_pending;
  logic              busy;
  logic              seq_ready;
  logic              in_blk0;
  logic              in_blk1;
  logic              addr_bad;
  logic              blk_locked;
  logic [7:0]        status_byte;

  // -------------------------------------------------------------------------
  // Address checks for the second command cycle
  // -------------------------------------------------------------------------
  // Block 0 needs the global enable as well as its own lock; block 1 only its lock.
  assign in_blk0    = (cmd_addr >= BLK0_LO) && (cmd_addr <= BLK0_HI);
  assign in_blk1    = (cmd_addr >= BLK1_LO) && (cmd_addr <= BLK1_HI);
  assign addr_bad   = !in_blk0 && !in_blk1;
  assign blk_locked = (in_blk0 && (!global_rewrite_enable || block0_rewrite_lock))
                    || (in_blk1 && block1_rewrite_lock);

  // Busy ends in the very cycle done arrives, so ready rises with completion.
  assign busy      = (phase_r == FSEC_PH_BUSY_PROG) || (phase_r == FSEC_PH_BUSY_ERASE);
  assign seq_ready = !(busy && !core_done);
  assign err_pending = prog_err || erase_err;

  // -------------------------------------------------------------------------
  // Command sequencing
  // -------------------------------------------------------------------------
  // Writes during an auto operation are ignored; the core cannot take them.
  always_comb begin
    phase_nxt       = phase_r;
    status_mode_nxt = status_mode_r;
    seq_err         = 1'b0;
    clr_cmd         = 1'b0;
    prog_start_nxt  = 1'b0;
    erase_start_nxt = 1'b0;
    prog_fail       = 1'b0;
    erase_fail      = 1'b0;
    case (phase_r)
      FSEC_PH_IDLE: begin
        if (cmd_wr) begin
          case (cmd_wdata)
            CMD_READ_ARRAY:   status_mode_nxt = 1'b0;
            CMD_READ_STATUS:  status_mode_nxt = 1'b1;
            CMD_CLEAR_STATUS: clr_cmd = 1'b1;
            CMD_PROGRAM: begin
              if (!err_pending) begin
                phase_nxt = FSEC_PH_PROG2;
              end
            end
            CMD_BLOCK_ERASE: begin
              if (!err_pending) begin
                phase_nxt = FSEC_PH_ERASE2;
              end
            end
            default: seq_err = 1'b1;
          endcase
        end
      end
      FSEC_PH_PROG2: begin
        if (cmd_wr) begin
          phase_nxt = FSEC_PH_IDLE;
          if (cmd_wdata == CMD_READ_ARRAY) begin
            status_mode_nxt = 1'b0;
          end else if (cmd_addr != addr_r || addr_bad || blk_locked) begin
            seq_err = 1'b1;
          end else begin
            phase_nxt       = FSEC_PH_BUSY_PROG;
            prog_start_nxt  = 1'b1;
            status_mode_nxt = 1'b1;
          end
        end
      end
      FSEC_PH_ERASE2: begin
        if (cmd_wr) begin
          phase_nxt = FSEC_PH_IDLE;
          if (cmd_wdata == CMD_READ_ARRAY) begin
            status_mode_nxt = 1'b0;
          end else if (cmd_wdata != CMD_ERASE_CONFIRM || addr_bad || blk_locked) begin
            seq_err = 1'b1;
          end else begin
            phase_nxt       = FSEC_PH_BUSY_ERASE;
            erase_start_nxt = 1'b1;
            status_mode_nxt = 1'b1;
          end
        end
      end
      FSEC_PH_BUSY_PROG: begin
        if (core_done) begin
          phase_nxt = FSEC_PH_IDLE;
          prog_fail = core_fail;
        end
      end
      FSEC_PH_BUSY_ERASE: begin
        if (core_done) begin
          phase_nxt  = FSEC_PH_IDLE;
          erase_fail = core_fail;
        end
      end
      default: phase_nxt = FSEC_PH_IDLE;
    endcase
  end

  // Phase and read mode; reset leaves the device in read array mode.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_r       <= FSEC_PH_IDLE;
      status_mode_r <= 1'b0;
    end else begin
      phase_r       <= phase_nxt;
      status_mode_r <= status_mode_nxt;
    end
  end

  // Address and data capture on first and second command cycles, and start strobes towards the flash core.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_r        <= '0;
      wdata_r       <= 8'h00;
      prog_start_r  <= 1'b0;
      erase_start_r <= 1'b0;
    end else begin
      prog_start_r  <= prog_start_nxt;
      erase_start_r <= erase_start_nxt;
      if (cmd_wr && (phase_r == FSEC_PH_IDLE || phase_r == FSEC_PH_PROG2
                     || phase_r == FSEC_PH_ERASE2)) begin
        addr_r  <= cmd_addr;
        wdata_r <= cmd_wdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Sticky error bits
  // -------------------------------------------------------------------------
  // A sequence error marks both bits; an operation failure marks only its own.
  fsec_sticky_flag #(.RST_VAL(PROG_ERR_RST)) u_prog_err (
    .clock (clock),
    .nrst  (nrst),
    .set   (seq_err || prog_fail),
    .clr   (clr_cmd),
    .flag  (prog_err)
  );

  fsec_sticky_flag #(.RST_VAL(ERASE_ERR_RST)) u_erase_err (
    .clock (clock),
    .nrst  (nrst),
    .set   (seq_err || erase_fail),
    .clr   (clr_cmd),
    .flag  (erase_err)
  );

  // -------------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------------
  // Reserved bits read as zero.
  always_comb begin
    status_byte                     = 8'h00;
    status_byte[STAT_PROG_ERR_POS]  = prog_err;
    status_byte[STAT_ERASE_ERR_POS] = erase_err;
    status_byte[STAT_READY_POS]     = seq_ready;
  end

  // Read data is held until the next read so the issuer may sample late.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= 8'h00;
    end else if (cmd_rd) begin
      rd_data_r <= status_mode_r ? status_byte : array_rdata;
    end
  end

  assign status_read_data       = rd_data_r;
  assign core_prog_start        = prog_start_r;
  assign core_erase_start       = erase_start_r;
  assign core_addr              = addr_r;
  assign core_wdata             = wdata_r;
  assign sequencer_ready_mirror = seq_ready;
  assign program_error_mirror   = prog_err;
  assign erase_error_mirror     = erase_err;
  assign status_mode            = status_mode_r;
  // Only the asynchronous serial modes exist on this device.
  assign serial_mode_ok = (serial_mode_sel == SER_MODE_2) || (serial_mode_sel == SER_MODE_3);

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  AST_BUSY_READY: assert property (@(posedge clock) disable iff (!nrst)
    (busy && !core_done) |-> !sequencer_ready_mirror)
    else $error("Ready shown while an auto operation runs.");

  AST_DONE_READY: assert property (@(posedge clock) disable iff (!nrst)
    (busy && core_done) |-> sequencer_ready_mirror ##1 (phase_r == FSEC_PH_IDLE))
    else $error("Ready did not rise with completion.");

  AST_STATUS_BYTE: assert property (@(posedge clock) disable iff (!nrst)
    (cmd_rd && status_mode_r) |=> (status_read_data == {$past(seq_ready), 1'b0,
      $past(erase_err), $past(prog_err), 4'h0}))
    else $error("Status byte layout wrong.");

  AST_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    (clr_cmd && !seq_err) |=> (!prog_err && !erase_err))
    else $error("Clear status left an error bit set.");

  AST_REFUSE: assert property (@(posedge clock) disable iff (!nrst)
    (phase_r == FSEC_PH_IDLE && err_pending && cmd_wr
     && (cmd_wdata == CMD_PROGRAM || cmd_wdata == CMD_BLOCK_ERASE))
    |=> (phase_r == FSEC_PH_IDLE) ##1 (!core_prog_start && !core_erase_start))
    else $error("Command accepted with an error pending.");

  AST_BAD_CODE: assert property (@(posedge clock) disable iff (!nrst)
    (phase_r == FSEC_PH_IDLE && cmd_wr && cmd_wdata != CMD_READ_ARRAY
     && cmd_wdata != CMD_READ_STATUS && cmd_wdata != CMD_CLEAR_STATUS
     && cmd_wdata != CMD_PROGRAM && cmd_wdata != CMD_BLOCK_ERASE)
    |=> (prog_err && erase_err))
    else $error("Unknown code did not raise a sequence error.");

  AST_ERASE_DATA: assert property (@(posedge clock) disable iff (!nrst)
    (phase_r == FSEC_PH_ERASE2 && cmd_wr && cmd_wdata != CMD_ERASE_CONFIRM
     && cmd_wdata != CMD_READ_ARRAY) |=> (prog_err && erase_err && !core_erase_start))
    else $error("Bad erase confirm not flagged.");

  AST_LOCKED: assert property (@(posedge clock) disable iff (!nrst)
    ((phase_r == FSEC_PH_PROG2 || phase_r == FSEC_PH_ERASE2) && cmd_wr
     && cmd_wdata != CMD_READ_ARRAY && (blk_locked || addr_bad))
    |=> (prog_err && erase_err && phase_r == FSEC_PH_IDLE && !core_prog_start && !core_erase_start))
    else $error("Locked or unmapped target was started.");

  AST_ERASE_FAIL: assert property (@(posedge clock) disable iff (!nrst)
    (phase_r == FSEC_PH_BUSY_ERASE && core_done && core_fail && !prog_err)
    |=> (erase_err && !prog_err))
    else $error("Erase failure marked wrong bits.");

  AST_PROG_FAIL: assert property (@(posedge clock) disable iff (!nrst)
    (phase_r == FSEC_PH_BUSY_PROG && core_done && core_fail && !erase_err)
    |=> (prog_err && !erase_err))
    else $error("Program failure marked wrong bits.");

  AST_READ_ARRAY_2ND: assert property (@(posedge clock) disable iff (!nrst)
    ((phase_r == FSEC_PH_PROG2 || phase_r == FSEC_PH_ERASE2) && cmd_wr
     && cmd_wdata == CMD_READ_ARRAY)
    |=> (phase_r == FSEC_PH_IDLE && !status_mode_r && $stable(prog_err) && $stable(erase_err)))
    else $error("Read-array in second cycle mishandled.");

  COV_PROG_OK: cover property (@(posedge clock) disable iff (!nrst)
    phase_r == FSEC_PH_BUSY_PROG && core_done && !core_fail);
  COV_ERASE_OK: cover property (@(posedge clock) disable iff (!nrst)
    phase_r == FSEC_PH_BUSY_ERASE && core_done && !core_fail);
  COV_SEQ_ERR: cover property (@(posedge clock) disable iff (!nrst) seq_err);
  COV_CLEAR: cover property (@(posedge clock) disable iff (!nrst) clr_cmd && err_pending);

endmodule : fsec_status_check

`default_nettype wire

// ==== testbench/fsec_core_model.sv ====
// Behavioural flash core that answers auto-program and auto-erase starts.
// Assumes one-cycle start pulses from the status checker on the rising clock edge.

`timescale 1ns/100ps
`default_nettype none

module fsec_core_model #(
  parameter int DELAY = 6
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic fail_cfg,
  output var  logic core_done,
  output var  logic core_fail
);
  int   cnt_r;
  logic fail_r;

  // Done comes DELAY cycles after a start; the fail line toggles outside done so nobody may rely on it.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r     <= 0;
      fail_r    <= 1'b0;
      core_done <= 1'b0;
      core_fail <= 1'b0;
    end else begin
      core_done <= 1'b0;
      core_fail <= ~core_fail;
      if (start) begin
        cnt_r  <= DELAY;
        fail_r <= fail_cfg;
      end else if (cnt_r == 1) begin
        cnt_r     <= 0;
        core_done <= 1'b1;
        core_fail <= fail_r;
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule : fsec_core_model

`default_nettype wire

// ==== testbench/fsec_status_check_test.sv ====
// Self-checking bench for the flash status and error checker.
// Assumes the core model beside it and inputs driven on the falling clock edge.

`timescale 1ns/100ps
`default_nettype none

module fsec_status_check_test;
  import fsec_pkg::*;
  typedef struct packed {
    logic [7:0]  first;
    logic [7:0]  second;
    logic        two;
    logic [15:0] addr;
    logic        fail;
    logic        go;
    logic [7:0]  exp;
  } fsec_row_type;

  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_wr = 1'b0;
  logic        cmd_rd = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0]  cmd_wdata = 8'h00;
  logic [7:0]  array_rdata = 8'h5a;
  logic        gl_en = 1'b1;
  logic        lock0 = 1'b0;
  logic        lock1 = 1'b0;
  logic [1:0]  mode_sel = 2'h0;
  logic        fail_cfg = 1'b0;
  logic [7:0]  status_read_data;
  logic        prog_go, erase_go, core_done, core_fail, serial_mode_ok;
  logic        sequencer_ready_mirror, erase_error_mirror, program_error_mirror, status_mode;
  logic [7:0]  n_start = 8'h00;
  logic [7:0]  pre;
  logic [15:0] core_addr;
  logic [7:0]  core_wdata;
  int          err_total = 0;
  int          num_checks = 0;
  fsec_row_type rows [9] = '{
    '{8'h40, 8'h5a, 1'b1, 16'he010, 1'b0, 1'b1, 8'h80},
    '{8'h40, 8'ha5, 1'b1, 16'he011, 1'b1, 1'b1, 8'h90},
    '{8'h20, 8'hd0, 1'b1, 16'hf000, 1'b0, 1'b1, 8'h80},
    '{8'h20, 8'hd0, 1'b1, 16'hf100, 1'b1, 1'b1, 8'ha0},
    '{8'h20, 8'h33, 1'b1, 16'hf000, 1'b0, 1'b0, 8'hb0},
    '{8'h12, 8'h00, 1'b0, 16'he000, 1'b0, 1'b0, 8'hb0},
    '{8'h40, 8'h11, 1'b1, 16'h1000, 1'b0, 1'b0, 8'hb0},
    '{8'h20, 8'hd0, 1'b1, 16'h2000, 1'b0, 1'b0, 8'hb0},
    '{8'h20, 8'hff, 1'b1, 16'he000, 1'b0, 1'b0, 8'h80}
  };

  always #2 clock = ~clock;

  // Starts are counted here so refused commands show up as a missing pulse.
  always @(posedge clock) begin
    if (prog_go === 1'b1 || erase_go === 1'b1) n_start <= n_start + 8'h01;
  end

  fsec_status_check fsec_status_check_i (
    .clock(clock), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .status_read_data(status_read_data), .array_rdata(array_rdata),
    .global_rewrite_enable(gl_en), .block0_rewrite_lock(lock0), .block1_rewrite_lock(lock1),
    .core_prog_start(prog_go), .core_erase_start(erase_go), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_done(core_done), .core_fail(core_fail), .serial_mode_sel(mode_sel),
    .serial_mode_ok(serial_mode_ok), .sequencer_ready_mirror(sequencer_ready_mirror),
    .erase_error_mirror(erase_error_mirror), .program_error_mirror(program_error_mirror),
    .status_mode(status_mode));

  fsec_core_model fsec_core_model_i (
    .clock(clock), .nrst(nrst), .start(prog_go | erase_go), .fail_cfg(fail_cfg),
    .core_done(core_done), .core_fail(core_fail));

  // ---------------------------------------------------------------------------
  // Bus tasks and comparisons
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string what);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e, input string what);
    chk8({7'h00, g}, {7'h00, e}, what);
  endtask : chk1

  // One write cycle; the strobe drops a cycle later, so writes never share a time step.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    cmd_addr  = a;
    cmd_wdata = d;
    cmd_wr    = 1'b1;
    @(negedge clock);
    cmd_wr = 1'b0;
  endtask : wr

  task automatic rd_status(input logic [7:0] e, input string what);
    wr(16'he000, CMD_READ_STATUS);
    @(negedge clock);
    cmd_addr = 16'he123;
    cmd_rd   = 1'b1;
    @(negedge clock);
    cmd_rd = 1'b0;
    chk8(status_read_data, e, what);
    chk1(program_error_mirror, e[4], "prog mirror");
    chk1(erase_error_mirror, e[5], "erase mirror");
  endtask : rd_status

  task automatic wait_ready();
    int n;
    n = 0;
    while (sequencer_ready_mirror !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      $display("[FAIL] %0t ready never returned", $time);
      give_verdict();
    end
  endtask : wait_ready

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock);
    chk1(sequencer_ready_mirror, 1'b1, "reset ready");
    chk1(program_error_mirror, 1'b0, "reset prog");
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(16'he000, CMD_CLEAR_STATUS);
      fail_cfg = rows[i].fail;
      pre = n_start;
      wr(rows[i].addr, rows[i].first);
      if (rows[i].two) wr(rows[i].addr, rows[i].second);
      @(negedge clock);
      chk1(sequencer_ready_mirror, ~rows[i].go, "busy");
      wait_ready();
      chk8(n_start - pre, {7'h00, rows[i].go}, "starts");
      rd_status(rows[i].exp, "row status");
    end
    // A read-array byte ends a program command too and leaves status mode.
    pre = n_start;
    wr(16'he020, CMD_PROGRAM);
    wr(16'he020, CMD_READ_ARRAY);
    chk1(status_mode, 1'b0, "array mode");
    chk8(n_start, pre, "dropped");
    // In read array mode a read returns the array byte, not the status byte.
    @(negedge clock);
    cmd_addr = 16'he020;
    cmd_rd   = 1'b1;
    @(negedge clock);
    cmd_rd = 1'b0;
    chk8(status_read_data, 8'h5a, "array read");
    // Each lock case must refuse the command and flag a sequence error.
    for (int k = 0; k < 3; k++) begin
      wr(16'he000, CMD_CLEAR_STATUS);
      gl_en = (k != 0);
      lock0 = (k == 1);
      lock1 = (k == 2);
      pre = n_start;
      wr((k == 2) ? 16'hf004 : 16'he004, (k == 0) ? CMD_BLOCK_ERASE : CMD_PROGRAM);
      wr((k == 2) ? 16'hf004 : 16'he004, (k == 0) ? CMD_ERASE_CONFIRM : 8'h3c);
      repeat (3) @(negedge clock);
      chk8(n_start, pre, "locked");
      rd_status(8'hb0, "lock status");
    end
    gl_en = 1'b1;
    lock1 = 1'b0;
    // Errors pending: both rewrite commands are refused and the bits stay.
    pre = n_start;
    wr(16'he030, CMD_PROGRAM);
    wr(16'he030, 8'h77);
    wr(16'hf000, CMD_BLOCK_ERASE);
    wr(16'hf000, CMD_ERASE_CONFIRM);
    repeat (3) @(negedge clock);
    chk8(n_start, pre, "refused");
    rd_status(8'hb0, "sticky");
    wr(16'he000, CMD_CLEAR_STATUS);
    rd_status(8'h80, "cleared");
    wr(16'he030, CMD_PROGRAM);
    wr(16'he030, 8'h77);
    repeat (2) @(negedge clock);
    chk8(n_start, pre + 8'h01, "accepted");
    chk8(core_wdata, 8'h77, "core data");
    chk8(core_addr[15:8], 8'he0, "core addr hi");
    chk8(core_addr[7:0], 8'h30, "core addr lo");
    wait_ready();
    // A reset in mid-run wipes the sticky bits.
    wr(16'he000, 8'h12);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    chk1(program_error_mirror, 1'b0, "rst prog");
    chk1(erase_error_mirror, 1'b0, "rst erase");
    chk1(sequencer_ready_mirror, 1'b1, "rst ready");
    chk8(status_read_data, 8'h00, "rst data");
    nrst = 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode_sel = m[1:0];
      @(negedge clock);
      chk1(serial_mode_ok, m >= 2, "serial mode");
    end
    give_verdict();
  end
endmodule : fsec_status_check_test

`default_nettype wire
